// File: core/smc_modem_pins.sv
`timescale 1ns/1ps
`include "smc_params.svh"
// Contract
// - Each port's clear-to-send level appears in handshake status bit 4; port A's status reads 0 while its pin is GPIO.
// - Request-to-send output is driven low when data is ready to send.
// - Port A terminal-ready output is driven low when ready to talk.
// - Port A request-to-send pin sampled at reset gives config bit 26.6.
// - Address strap high places the configuration port at 4EH.
// - Port A terminal-ready pin sampled at reset gives config bit 24.1.
// - ROM interface enabled only when the ROM strap latched high.
// - Port A clear-to-send pin may act as GPIO port 6 bit 7.
// - Port B set-ready pin may act as GPIO port 4 bit 6.
// - Port B terminal-ready output is driven low when ready to talk.
module smc_modem_pins
  import smc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Modem-side inputs.
  input wire logic port_a_clear_to_send_n,
  input wire logic port_b_clear_to_send_n,
  input wire logic port_a_set_ready_n,
  input wire logic port_b_set_ready_n,
  // Strap-capable port A pins: input level, output and enable; then port B outputs.
  input wire logic port_a_request_send_n_in,
  output logic port_a_request_send_n,
  output logic port_a_request_send_oe,
  input wire logic port_a_terminal_ready_n_in,
  output logic port_a_terminal_ready_n,
  output logic port_a_terminal_ready_oe,
  output logic port_b_request_send_n,
  output logic port_b_terminal_ready_n,
  // UART core side, active high requests.
  input wire logic portAReqSend,
  input wire logic portATermReady,
  input wire logic portBReqSend,
  input wire logic portBTermReady,
  // Pin-function selection: high hands the pin to GPIO.
  input wire logic selGpioP6b7,
  input wire logic selGpioP4b6,
  output logic [7:0] portAHandshake,
  output logic [7:0] portBHandshake,
  output logic gpio_p6_b7,
  output logic gpio_p4_b6,
  output logic config_addr_strap,
  output logic rom_enable_strap,
  output logic rom_enable_bit,
  output logic [7:0] configAddr,
  output logic [7:0] config_reg_26,
  output logic [7:0] config_reg_24
);

  // --------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------
  smc_phase_e phase_q;
  logic addrStrap_q;
  logic romStrap_q;
  wire logic captureNow = (phase_q == SMC_STRAP);

  // Reset holds constants only; straps are caught on the first enabled edge
  // after release, while the pins are still undriven inputs.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= SMC_STRAP;
      addrStrap_q <= 1'b0;
      romStrap_q <= 1'b0;
    end else if (clkEn && captureNow) begin
      phase_q <= SMC_RUN;
      addrStrap_q <= port_a_request_send_n_in;
      romStrap_q <= port_a_terminal_ready_n_in;
    end
  end

  // --------------------------------------------------------------------
  // Modem outputs and status
  // --------------------------------------------------------------------
  wire logic runPhase = (phase_q == SMC_RUN);
  smc_byte_t hsA_d;
  smc_byte_t hsB_d;
  smc_byte_t cfg26_d;
  smc_byte_t cfg24_d;

  // Status bytes carry only the clear-to-send level; other bits zero.
  always_comb begin
    hsA_d = 8'h00;
    hsB_d = 8'h00;
    hsA_d[`SMC_HS_CTS_BIT] = port_a_clear_to_send_n;
    hsB_d[`SMC_HS_CTS_BIT] = port_b_clear_to_send_n;
    cfg26_d = 8'h00;
    cfg24_d = 8'h00;
    cfg26_d[`SMC_CFG26_ADDR_BIT] = addrStrap_q;
    cfg24_d[`SMC_CFG24_ROM_BIT] = romStrap_q;
  end

  // Every output is registered; request lines idle high (inactive).
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_request_send_n <= 1'b1;
      port_a_request_send_oe <= 1'b0;
      port_a_terminal_ready_n <= 1'b1;
      port_a_terminal_ready_oe <= 1'b0;
      port_b_request_send_n <= 1'b1;
      port_b_terminal_ready_n <= 1'b1;
      portAHandshake <= 8'h00;
      portBHandshake <= 8'h00;
      gpio_p6_b7 <= 1'b0;
      gpio_p4_b6 <= 1'b0;
      config_addr_strap <= 1'b0;
      rom_enable_strap <= 1'b0;
      rom_enable_bit <= 1'b0;
      configAddr <= `SMC_CFG_ADDR_LO;
      config_reg_26 <= 8'h00;
      config_reg_24 <= 8'h00;
    end else if (clkEn) begin
      port_a_request_send_n <= ~portAReqSend;
      port_a_request_send_oe <= runPhase;
      port_a_terminal_ready_n <= ~portATermReady;
      port_a_terminal_ready_oe <= runPhase;
      port_b_request_send_n <= ~portBReqSend;
      port_b_terminal_ready_n <= ~portBTermReady;
      // GPIO selection hides the modem meaning; status then reads 0.
      portAHandshake <= selGpioP6b7 ? 8'h00 : hsA_d;
      portBHandshake <= hsB_d;
      gpio_p6_b7 <= selGpioP6b7 & port_a_clear_to_send_n;
      gpio_p4_b6 <= selGpioP4b6 & port_b_set_ready_n;
      config_addr_strap <= addrStrap_q;
      rom_enable_strap <= romStrap_q;
      rom_enable_bit <= romStrap_q;
      configAddr <= addrStrap_q ? `SMC_CFG_ADDR_HI
                                : `SMC_CFG_ADDR_LO;
      config_reg_26 <= cfg26_d;
      config_reg_24 <= cfg24_d;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Port B spare status bits must stay clear so software never reads noise.
  wire smc_byte_t hsSpareB = portBHandshake & ~(8'h01 << `SMC_HS_CTS_BIT);

  // A strap capture, then two enabled edges until the outputs show it.
  sequence s_capture;
    clkEn && captureNow;
  endsequence
  sequence s_strap_seen;
    s_capture ##1 clkEn [*2];
  endsequence

  // Status bytes follow the clear-to-send pins one enabled edge later, except port A's while its pin is GPIO.
  a_cts_status: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn |=> portBHandshake[`SMC_HS_CTS_BIT] ==
      $past(port_b_clear_to_send_n))
    else $error("CTS status bit mismatch");

  a_cts_port_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn && !selGpioP6b7 |=> portAHandshake[`SMC_HS_CTS_BIT] ==
      $past(port_a_clear_to_send_n))
    else $error("CTS A status bit mismatch");

  a_hs_spare: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    hsSpareB == 8'h00)
    else $error("Spare status bits set");

  // Modem control outputs are the inverted core requests.
  a_rts_drive: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn |=> port_b_request_send_n == !$past(portBReqSend))
    else $error("RTS drive wrong");

  a_rts_port_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn |=> port_a_request_send_n == !$past(portAReqSend))
    else $error("RTS A drive wrong");

  a_dtr_drive: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn |=> port_a_terminal_ready_n == !$past(portATermReady))
    else $error("DTR A drive wrong");

  a_port_b_terminal_ready_n_drive: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn |=> port_b_terminal_ready_n == !$past(portBTermReady))
    else $error("DTR B drive wrong");

  // Strap outcomes show the pin level seen at the capture edge.
  a_addr_strap: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s_strap_seen |-> config_reg_26[`SMC_CFG26_ADDR_BIT] ==
      $past(port_a_request_send_n_in, 2))
    else $error("Address strap not captured");

  a_cfg_addr: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn && runPhase |=> configAddr ==
      (addrStrap_q ? `SMC_CFG_ADDR_HI : `SMC_CFG_ADDR_LO))
    else $error("Config address wrong");

  a_rom_strap: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s_strap_seen |-> config_reg_24[`SMC_CFG24_ROM_BIT] ==
      $past(port_a_terminal_ready_n_in, 2))
    else $error("ROM strap not captured");

  a_rom_enable: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s_strap_seen |-> rom_enable_bit ==
      $past(port_a_terminal_ready_n_in, 2))
    else $error("ROM enable does not follow strap");

  // Strap pins are inputs until capture, then driven, and never relatch.
  a_pins_input: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    captureNow |-> !port_a_request_send_oe && !port_a_terminal_ready_oe)
    else $error("Strap pin driven too early");

  a_pins_driven: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn && runPhase |=> port_a_request_send_oe &&
      port_a_terminal_ready_oe)
    else $error("Strap pin not handed to output");

  a_strap_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    runPhase |=> $stable(addrStrap_q) && $stable(romStrap_q))
    else $error("Strap latch moved after capture");

  a_strap_low: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    captureNow |-> !config_addr_strap && !rom_enable_strap)
    else $error("Strap output high before capture");

  // GPIO views of the shared pins and the status they hide.
  a_gpio_cts: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn |=> gpio_p6_b7 ==
      ($past(selGpioP6b7) && $past(port_a_clear_to_send_n)))
    else $error("GPIO 6.7 level wrong");

  a_hs_gpio: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn && selGpioP6b7 |=> portAHandshake == 8'h00)
    else $error("Status not cleared in GPIO mode");

  a_gpio_sel: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn && !selGpioP4b6 |=> !gpio_p4_b6)
    else $error("GPIO 4.6 active while unselected");

  a_gpio_dsr: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clkEn |=> gpio_p4_b6 ==
      ($past(selGpioP4b6) && $past(port_b_set_ready_n)))
    else $error("GPIO 4.6 level wrong");

endmodule : smc_modem_pins

// File: core/smc_params.svh
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
// ----------------------------------------------------------------------
// Field positions and strap outcomes
// ----------------------------------------------------------------------
`define SMC_HS_CTS_BIT 4
`define SMC_CFG26_ADDR_BIT 6
`define SMC_CFG24_ROM_BIT 1
`define SMC_GP6_CTS_BIT 7
`define SMC_GP4_DSR_BIT 6
`define SMC_CFG_ADDR_HI 8'h4E
`define SMC_CFG_ADDR_LO 8'h2E
`endif

// File: core/smc_pkg.sv
package smc_pkg;
  // Strap sequencing: pins are inputs until the strap capture after reset.
  typedef enum logic [0:0] {
    SMC_STRAP = 1'b0,
    SMC_RUN = 1'b1
  } smc_phase_e;
  typedef logic [7:0] smc_byte_t;
endpackage : smc_pkg

// File: tb/smc_modem_model.sv
`timescale 1ns/1ps
// Modem side: status lines and the strap pull resistors on port A pins.
module smc_modem_model (
  input wire logic [3:0] lineLvl,
  input wire logic [1:0] strapUp,
  input wire logic rtsAOut,
  input wire logic rtsAOe,
  input wire logic dtrAOut,
  input wire logic dtrAOe,
  output logic aCts_n,
  output logic bCts_n,
  output logic aDsr_n,
  output logic bDsr_n,
  output logic rtsAPin,
  output logic dtrAPin
);
  // The modem drives its active-low status levels as the bench sets them.
  assign {aCts_n, bCts_n} = lineLvl[3:2];
  assign {aDsr_n, bDsr_n} = lineLvl[1:0];
  // A released strap pin falls to its resistor, so no stale value shows.
  assign rtsAPin = rtsAOe ? rtsAOut : strapUp[1];
  assign dtrAPin = dtrAOe ? dtrAOut : strapUp[0];
endmodule : smc_modem_model

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "smc_params.svh"
`define CHK(n, e, g) check(n, 8'(e), 8'(g))
module testbench;
  logic ref_clk = 0, arst_n = 0, clkEn = 1;
  logic [3:0] lineLvl = 4'hF, req = 4'h0;
  logic [1:0] strapUp = 2'h0, sel = 2'h0;
  logic aCts, bCts, aDsr, bDsr, rtsPin, dtrPin, aRts, rtsOe, aDtr, dtrOe;
  logic bRts, bDtr, gpCts, gpDsr, addrS, romS, romB;
  logic [7:0] hsA, hsB, cfgAddr, cfg26, cfg24;
  logic [16:0] lfsrQ = 17'h18125;
  int err_count = 0, num_checks = 0;
  // Free-running 25 MHz clock.
  always #20 ref_clk = ~ref_clk;
  smc_modem_model smc_modem_model_inst (.lineLvl(lineLvl),
    .strapUp(strapUp), .rtsAOut(aRts), .rtsAOe(rtsOe), .dtrAOut(aDtr),
    .dtrAOe(dtrOe), .aCts_n(aCts), .bCts_n(bCts), .aDsr_n(aDsr),
    .bDsr_n(bDsr), .rtsAPin(rtsPin), .dtrAPin(dtrPin));
  smc_modem_pins smc_modem_pins_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .clkEn(clkEn), .port_a_clear_to_send_n(aCts),
    .port_b_clear_to_send_n(bCts), .port_a_set_ready_n(aDsr),
    .port_b_set_ready_n(bDsr), .port_a_request_send_n_in(rtsPin),
    .port_a_request_send_n(aRts), .port_a_request_send_oe(rtsOe),
    .port_a_terminal_ready_n_in(dtrPin), .port_a_terminal_ready_n(aDtr),
    .port_a_terminal_ready_oe(dtrOe), .port_b_request_send_n(bRts),
    .port_b_terminal_ready_n(bDtr), .portAReqSend(req[3]),
    .portATermReady(req[2]), .portBReqSend(req[1]),
    .portBTermReady(req[0]), .selGpioP6b7(sel[1]), .selGpioP4b6(sel[0]),
    .portAHandshake(hsA), .portBHandshake(hsB), .gpio_p6_b7(gpCts),
    .gpio_p4_b6(gpDsr), .config_addr_strap(addrS), .rom_enable_strap(romS),
    .rom_enable_bit(romB), .configAddr(cfgAddr), .config_reg_26(cfg26),
    .config_reg_24(cfg24));
  function automatic logic [16:0] lfsr_next(logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr_next
  // Status byte holds the clear-to-send level unless the pin went to GPIO.
  function automatic logic [7:0] hs_exp(logic cts, logic gp);
    logic [7:0] r;
    r = 8'h00;
    if (!gp) r[`SMC_HS_CTS_BIT] = cts;
    return r;
  endfunction : hs_exp
  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // Reset with one strap setting, then look at the latched outcome.
  task automatic strap_run(logic [1:0] s);
    strapUp = s;
    arst_n = 0;
    repeat (6) @(negedge ref_clk);
    `CHK("oeRst", 2'b00, {rtsOe, dtrOe});
    `CHK("cfgRst", `SMC_CFG_ADDR_LO, cfgAddr);
    arst_n = 1;
    repeat (3) @(negedge ref_clk);
    `CHK("addrStrap", s[1], addrS);
    `CHK("cfg26", 8'(s[1]) << `SMC_CFG26_ADDR_BIT, cfg26);
    `CHK("cfgAddr", s[1] ? `SMC_CFG_ADDR_HI : `SMC_CFG_ADDR_LO, cfgAddr);
    `CHK("romStrap", s[0], romS);
    `CHK("cfg24", 8'(s[0]) << `SMC_CFG24_ROM_BIT, cfg24);
    `CHK("romEn", s[0], romB);
    `CHK("oeRun", 2'b11, {rtsOe, dtrOe});
  endtask : strap_run
  // Random levels with freezes; outputs follow the last enabled sample.
  task automatic rand_run();
    logic [9:0] tIn;
    tIn = {lineLvl, req, sel};
    for (int i = 0; i < 40; i++) begin
      lfsrQ = lfsr_next(lfsrQ);
      {lineLvl, req, sel} = i == 0 ? 10'h000 : i == 1 ? 10'h3FF : lfsrQ[9:0];
      clkEn = i < 2 || lfsrQ[12];
      @(negedge ref_clk);
      if (clkEn) tIn = {lineLvl, req, sel};
      `CHK("aRts", !tIn[5], aRts);
      `CHK("bRts", !tIn[3], bRts);
      `CHK("aDtr", !tIn[4], aDtr);
      `CHK("bDtr", !tIn[2], bDtr);
      `CHK("hsA", hs_exp(tIn[9], tIn[1]), hsA);
      `CHK("hsB", hs_exp(tIn[8], 1'b0), hsB);
      `CHK("gpCts", tIn[9] & tIn[1], gpCts);
      `CHK("gpDsr", tIn[6] & tIn[0], gpDsr);
    end
  endtask : rand_run
  // Main sequence, then a watchdog well past the expected run length.
  initial begin
    for (int s = 0; s < 4; s++) strap_run(2'(s));
    $display("strap test done");
    rand_run();
    $display("random test done");
    finish_test();
  end
  initial begin
    #40000;
    err_count++;
    finish_test();
  end
endmodule : testbench
